// ==== common/ulc_pkg.sv ====
// package: offsets, field positions, reset values and widths of the line and mode control
// assumes: an 8-bit register port supplied by the host-side SPI/I2C front end
package ulc_pkg;
  // register offsets
  localparam logic [7:0] ADDR_MODE = 8'h0A;
  localparam logic [7:0] ADDR_LINE = 8'h0B;
  localparam logic [7:0] ADDR_TOUT = 8'h0C;
  // reset values
  localparam logic [7:0] MODE_RST = 8'h00;
  localparam logic [7:0] LINE_RST = 8'h05;
  localparam logic [7:0] TOUT_RST = 8'h00;
  // channel_mode_control fields
  localparam int M_ECHO = 7;
  localparam int M_MDROP = 6;
  localparam int M_LOOP = 5;
  localparam int M_SPEC = 4;
  localparam int M_EINV = 3;
  localparam int M_TINV = 2;
  localparam int M_FLUSH = 1;
  localparam int M_SRST = 0;
  // line_framing_control fields
  localparam int L_RTS = 7;
  localparam int L_BRK = 6;
  localparam int L_FORCE = 5;
  localparam int L_EVEN = 4;
  localparam int L_PAR = 3;
  localparam int L_STOP = 2;
  localparam int L_LEN_HI = 1;
  localparam int L_LEN_LO = 0;
  // field widths and scales
  localparam logic [2:0] WORD_BASE = 3'h5;
  localparam logic [2:0] TRIG_SHIFT = 3'h3;
  localparam int LVL_W = 8;
  localparam int NCHAR = 4;
  // frame overhead in half bit times: start plus one stop
  localparam logic [4:0] HB_START_STOP = 5'h04;
  localparam logic [4:0] HB_ONE_BIT = 5'h02;
  localparam logic [4:0] HB_HALF_BIT = 5'h01;
endpackage

// ==== hw/ulc_frame_len.sv ====
// frame length in half bit times from the current framing setting
// assumes: purely combinational, read in the same clock domain
`timescale 1ns/1ps
module ulc_frame_len (
  input wire logic [7:0] line_cfg,
  input wire logic multidrop,
  output logic [4:0] half_bits
);
  logic [4:0] data_hb;
  logic [4:0] par_hb;
  logic [4:0] stop_hb;
  always_comb begin
    // four bits wide so that an 8-bit word does not wrap to zero
    data_hb = {(4'(line_cfg[ulc_pkg::L_LEN_HI:ulc_pkg::L_LEN_LO]) + 4'(ulc_pkg::WORD_BASE)),
      1'b0};
    // multidrop keeps the ninth bit in the parity slot
    par_hb = (line_cfg[ulc_pkg::L_PAR] || multidrop) ? ulc_pkg::HB_ONE_BIT : 5'h00;
    stop_hb = 5'h00;
    if (line_cfg[ulc_pkg::L_STOP]) begin
      stop_hb = (line_cfg[ulc_pkg::L_LEN_HI:ulc_pkg::L_LEN_LO] == 2'h0) ?
        ulc_pkg::HB_HALF_BIT : ulc_pkg::HB_ONE_BIT;
    end
    half_bits = 5'(data_hb + par_hb + stop_hb + ulc_pkg::HB_START_STOP);
  end
endmodule // ulc_frame_len

// ==== hw/ulc_line_ctrl.sv ====
// line and mode control of one serial channel: registers, framing, loopback, break,
// echo blocking, special characters, fifo event senses and receive timeout
// assumes: host register port, half-bit tick from the baud generator, fifo levels
// How it works
// - echo blocking drops rx while tx busy
// - blocking holds for programmed hold after tx
// - multidrop: ninth bit replaces parity, no checking
// - parity error flag reports ninth bit
// - loopback routes tx to rx, rts to cts
// - loopback tristates tx, rts keeps driving
// - match up to four characters, flag match
// - soft flow uses pair one; pair two matches
// - empty event sense set by invert bit
// - threshold event sense set by invert bit
// - flush empties both fifos until cleared
// - soft reset restores registers, clears fifos
// - rts follows its bit unless clock routed
// - break holds tx low until cleared
// - forced parity sends inverse of even sense
// - sense bit picks even or odd parity
// - parity disabled means no parity bit
// - stop bits: 1, 1.5 for 5-bit, else 2
// - extended 5-bit stop accepts over one bit
// - length field picks 5 to 8 data bits
// - timeout after programmed idle frame count
// - zero count disables the timeout
// - hold counts whole bit times, up to 15
// - threshold level is eight times field
`timescale 1ns/1ps
module ulc_line_ctrl (
  input wire logic clk,
  input wire logic nrst,
  // register port
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  // settings kept elsewhere in the channel
  input wire logic [3:0] hold_bits,
  input wire logic clock_out_on_handshake_pin,
  input wire logic auto_soft_flow_enable,
  input wire logic [3:0] rx_threshold_field,
  input wire logic [7:0] stop_char_one,
  input wire logic [7:0] stop_char_two,
  input wire logic [7:0] resume_char_one,
  input wire logic [7:0] resume_char_two,
  input wire logic [3:0] char_enable,
  input wire logic input_pin_qualify,
  input wire logic pin_match,
  // baud and datapath
  input wire logic half_bit_tick,
  input wire logic tx_busy,
  input wire logic tx_serial,
  input wire logic rx_char_valid,
  input wire logic [7:0] rx_char,
  input wire logic rx_ninth_bit,
  input wire logic rx_parity_bad,
  input wire logic [7:0] rx_fifo_level,
  // pins
  input wire logic rx_pin,
  input wire logic cts_pin,
  output logic tx_pin_o,
  output logic tx_pin_oe,
  output logic rts_pin_o,
  // to the datapath
  output logic rx_serial,
  output logic cts_internal,
  output logic rx_accept,
  output logic check_bit_enable,
  output logic check_sense_even,
  output logic constant_check_bit,
  output logic constant_level,
  output logic [3:0] data_bits,
  output logic extended_stop_select,
  output logic [4:0] frame_half_bits,
  output logic fifo_clear,
  output logic parity_flag,
  output logic match_char_event,
  output logic [1:0] flow_char_event,
  output logic rx_empty_event,
  output logic rx_threshold_event,
  output logic rx_idle_timeout
);
  typedef struct packed {
    logic [7:0] mode;
    logic [7:0] line;
    logic [7:0] tout;
    logic [7:0] rdata;
    logic [1:0] rx_sync;
    logic [1:0] cts_sync;
    logic tx_o;
    logic tx_oe;
    logic rts_o;
    logic tx_busy_d;
    logic [4:0] hold_cnt;
    logic [4:0] frame_hb;
    logic [7:0] frame_cnt;
    logic timer_run;
    logic timeout;
    logic par_flag;
    logic match_ev;
    logic [1:0] flow_ev;
    logic [7:0] lvl_d;
    logic empty_ev;
    logic trig_ev;
  } ulc_state_t;

  ulc_state_t s_q;
  ulc_state_t s_d;
  logic [4:0] frame_len;
  localparam int LVL_W_L = ulc_pkg::LVL_W;
  logic [LVL_W_L-1:0] trig_lvl;

  // frame length shared by the timeout counter
  ulc_frame_len u_len (
    .line_cfg(s_q.line),
    .multidrop(s_q.mode[ulc_pkg::M_MDROP]),
    .half_bits(frame_len)
  );

  function automatic logic char_hit(input logic [7:0] a, input logic [7:0] b,
    input logic en, input logic qual, input logic pin);
    char_hit = en && (a == b) && (!qual || pin);
  endfunction

  assign trig_lvl = 8'({rx_threshold_field, 3'h0});

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    logic blocked;
    logic in_loop;
    logic spec_on;
    logic soft_flow;
    blocked = 1'b0;
    in_loop = 1'b0;
    spec_on = 1'b0;
    soft_flow = 1'b0;
    s_d = s_q;
    // register writes; soft reset keeps the port alive but restores the mode, line and timeout registers
    if (reg_wr) begin
      case (reg_addr)
        ulc_pkg::ADDR_MODE: s_d.mode = reg_wdata;
        ulc_pkg::ADDR_LINE: s_d.line = reg_wdata;
        ulc_pkg::ADDR_TOUT: s_d.tout = reg_wdata;
        default: ;
      endcase
    end
    if (s_q.mode[ulc_pkg::M_SRST]) begin
      // only the soft reset bit itself stays writable while it is set
      s_d.line = ulc_pkg::LINE_RST;
      s_d.tout = ulc_pkg::TOUT_RST;
      s_d.mode = ulc_pkg::MODE_RST;
      s_d.mode[ulc_pkg::M_SRST] = !(reg_wr && reg_addr == ulc_pkg::ADDR_MODE &&
        !reg_wdata[ulc_pkg::M_SRST]);
    end
    case (reg_addr)
      ulc_pkg::ADDR_MODE: s_d.rdata = s_q.mode;
      ulc_pkg::ADDR_LINE: s_d.rdata = s_q.line;
      ulc_pkg::ADDR_TOUT: s_d.rdata = s_q.tout;
      default: s_d.rdata = 8'h00;
    endcase
    if (!reg_rd) begin
      s_d.rdata = s_q.rdata;
    end
    // pin synchronisers
    s_d.rx_sync = {s_q.rx_sync[0], rx_pin};
    s_d.cts_sync = {s_q.cts_sync[0], cts_pin};
    // tx pin: loopback tristates it, break forces low
    in_loop = s_q.mode[ulc_pkg::M_LOOP];
    s_d.tx_oe = !in_loop;
    s_d.tx_o = s_q.line[ulc_pkg::L_BRK] ? 1'b0 : tx_serial;
    // rts follows its bit only when the clock is not routed there
    s_d.rts_o = clock_out_on_handshake_pin ? s_q.rts_o : s_q.line[ulc_pkg::L_RTS];
    // echo hold: loaded with twice the hold at end of transmission, counts half bits
    s_d.tx_busy_d = tx_busy;
    if (tx_busy) begin
      s_d.hold_cnt = 5'h00;
    end else if (s_q.tx_busy_d) begin
      s_d.hold_cnt = {hold_bits, 1'b0};
    end else if (half_bit_tick && s_q.hold_cnt != 5'h00) begin
      s_d.hold_cnt = 5'(s_q.hold_cnt - 5'h01);
    end
    blocked = s_q.mode[ulc_pkg::M_ECHO] && (tx_busy || s_q.hold_cnt != 5'h00);
    // parity flag: ninth bit in multidrop, parity check otherwise
    if (rx_char_valid && !blocked) begin
      if (s_q.mode[ulc_pkg::M_MDROP]) begin
        s_d.par_flag = rx_ninth_bit;
      end else begin
        s_d.par_flag = s_q.line[ulc_pkg::L_PAR] && rx_parity_bad;
      end
    end
    // special characters; with soft flow the first pair is reserved for flow
    spec_on = s_q.mode[ulc_pkg::M_SPEC];
    soft_flow = auto_soft_flow_enable;
    s_d.match_ev = 1'b0;
    s_d.flow_ev = 2'h0;
    if (rx_char_valid && !blocked) begin
      s_d.match_ev = spec_on && (
        char_hit(rx_char, resume_char_two, char_enable[1], input_pin_qualify, pin_match) ||
        char_hit(rx_char, stop_char_two, char_enable[3], input_pin_qualify, pin_match) ||
        (!soft_flow && (
        char_hit(rx_char, resume_char_one, char_enable[0], input_pin_qualify, pin_match) ||
        char_hit(rx_char, stop_char_one, char_enable[2], input_pin_qualify, pin_match))));
      if (soft_flow) begin
        s_d.flow_ev = {rx_char == stop_char_one, rx_char == resume_char_one};
      end
    end
    // fifo level events
    s_d.lvl_d = rx_fifo_level;
    s_d.empty_ev = s_q.mode[ulc_pkg::M_EINV] ?
      (s_q.lvl_d == 8'h00 && rx_fifo_level != 8'h00) :
      (s_q.lvl_d != 8'h00 && rx_fifo_level == 8'h00);
    s_d.trig_ev = s_q.mode[ulc_pkg::M_TINV] ?
      (s_q.lvl_d >= trig_lvl && rx_fifo_level < trig_lvl) :
      (s_q.lvl_d <= trig_lvl && rx_fifo_level > trig_lvl);
    // receive timeout counted in frames of the current length
    s_d.frame_hb = s_q.frame_hb;
    if (rx_char_valid && !blocked) begin
      s_d.timer_run = (s_q.tout != 8'h00);
      s_d.frame_cnt = 8'h00;
      s_d.frame_hb = 5'h00;
      s_d.timeout = 1'b0;
    end else if (s_q.timer_run && half_bit_tick) begin
      if (5'(s_q.frame_hb + 5'h01) >= frame_len) begin
        s_d.frame_hb = 5'h00;
        s_d.frame_cnt = 8'(s_q.frame_cnt + 8'h01);
        if (8'(s_q.frame_cnt + 8'h01) == s_q.tout) begin
          s_d.timeout = 1'b1;
          s_d.timer_run = 1'b0;
        end
      end else begin
        s_d.frame_hb = 5'(s_q.frame_hb + 5'h01);
      end
    end
    if (s_q.tout == 8'h00) begin
      s_d.timeout = 1'b0;
      s_d.timer_run = 1'b0;
    end
    // flush and soft reset clear the timer with the fifos
    if (s_q.mode[ulc_pkg::M_FLUSH] || s_q.mode[ulc_pkg::M_SRST]) begin
      s_d.timer_run = 1'b0;
      s_d.timeout = 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!nrst) begin
      s_q <= '0;
      s_q.line <= ulc_pkg::LINE_RST;
      s_q.rx_sync <= 2'h3;
      s_q.cts_sync <= 2'h3;
      s_q.tx_o <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  logic md;
  assign md = s_q.mode[ulc_pkg::M_MDROP];
  assign reg_rdata = s_q.rdata;
  assign tx_pin_o = s_q.tx_o;
  assign tx_pin_oe = s_q.tx_oe;
  assign rts_pin_o = s_q.rts_o;
  // loopback feeds the transmitter straight back; idle line is high
  assign rx_serial = s_q.mode[ulc_pkg::M_LOOP] ? tx_serial : s_q.rx_sync[1];
  assign cts_internal = s_q.mode[ulc_pkg::M_LOOP] ? s_q.line[ulc_pkg::L_RTS] :
    s_q.cts_sync[1];
  assign rx_accept = !(s_q.mode[ulc_pkg::M_ECHO] && (tx_busy || s_q.hold_cnt != 5'h00));
  assign check_bit_enable = s_q.line[ulc_pkg::L_PAR] && !md;
  assign check_sense_even = s_q.line[ulc_pkg::L_EVEN];
  assign constant_check_bit = s_q.line[ulc_pkg::L_PAR] && s_q.line[ulc_pkg::L_FORCE];
  assign constant_level = !s_q.line[ulc_pkg::L_EVEN];
  assign data_bits = 4'(s_q.line[ulc_pkg::L_LEN_HI:ulc_pkg::L_LEN_LO]) +
    4'(ulc_pkg::WORD_BASE);
  assign extended_stop_select = s_q.line[ulc_pkg::L_STOP];
  assign frame_half_bits = frame_len;
  assign fifo_clear = s_q.mode[ulc_pkg::M_FLUSH] || s_q.mode[ulc_pkg::M_SRST];
  assign parity_flag = s_q.par_flag;
  assign match_char_event = s_q.match_ev;
  assign flow_char_event = s_q.flow_ev;
  assign rx_empty_event = s_q.empty_ev;
  assign rx_threshold_event = s_q.trig_ev;
  assign rx_idle_timeout = s_q.timeout;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);
  break_low_a: assert property (s_q.line[ulc_pkg::L_BRK] |=> !tx_pin_o)
    else $error("tx not low during break");
  loop_tri_a: assert property (s_q.mode[ulc_pkg::M_LOOP] |=> !tx_pin_oe)
    else $error("tx driven in loopback");
  rts_follow_a: assert property (!clock_out_on_handshake_pin |=>
    rts_pin_o == $past(s_q.line[ulc_pkg::L_RTS]))
    else $error("rts not following its bit");
  echo_drop_a: assert property (s_q.mode[ulc_pkg::M_ECHO] && tx_busy |-> !rx_accept)
    else $error("echo accepted during tx");
  srst_frame_a: assert property (s_q.mode[ulc_pkg::M_SRST] |=>
    s_q.line == ulc_pkg::LINE_RST)
    else $error("framing not reset");
  md_parity_a: assert property (md |-> !check_bit_enable)
    else $error("parity checked in multidrop");
  zero_tout_a: assert property (s_q.tout == 8'h00 |=> !rx_idle_timeout)
    else $error("timeout with zero count");
  flush_clr_a: assert property (s_q.mode[ulc_pkg::M_FLUSH] |-> fifo_clear)
    else $error("flush not clearing");
  empty_cov: cover property (rx_empty_event);
  trig_cov: cover property (rx_threshold_event);
  tout_cov: cover property (rx_idle_timeout);
endmodule // ulc_line_ctrl

// ==== testbench/ulc_xcvr_model.sv ====
// line transceiver model on the far side of the serial pins
// assumes: half-duplex bus with a pull-up, so our own transmit echoes back
`timescale 1ns/1ps
module ulc_xcvr_model (
  input wire logic tx_pin_o,
  input wire logic tx_pin_oe,
  input wire logic cts_drive,
  output logic line_level,
  output logic rx_pin,
  output logic cts_pin
);
  // released line floats to the pull-up level, not the last driven value
  assign line_level = tx_pin_oe ? tx_pin_o : 1'b1;
  assign rx_pin = line_level;
  assign cts_pin = cts_drive;
endmodule // ulc_xcvr_model

// ==== testbench/uart_line_and_mode_control_tb.sv ====
// self-checking bench of the line and mode control
// assumes: register port strobes of one cycle, inputs driven 1 ns after the edge
`timescale 1ns/1ps
module uart_line_and_mode_control_tb;
  logic clk, nrst, reg_wr, reg_rd, tick, busy, txs, rxv, ninth, clko, ctsd;
  logic [7:0] addr, wdata, rdata;
  logic [3:0] hold;
  logic tpo, toe, rts, rxs, ctsi, acc, cbe, cse, ccb, clv, ext, fclr, pflag, tout, line, rxp, ctsp;
  logic [4:0] fhb;
  logic asfe, qual, pm, pbad, mev, eev, tev;
  logic [3:0] thr, cen, dbits;
  logic [7:0] rch, lvl;
  logic [1:0] fev;
  int n_errors = 0;
  int num_checks = 0;
  ulc_line_ctrl DUT (.clk(clk), .nrst(nrst), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_addr(addr), .reg_wdata(wdata), .reg_rdata(rdata), .hold_bits(hold),
    .clock_out_on_handshake_pin(clko), .auto_soft_flow_enable(asfe),
    .rx_threshold_field(thr), .stop_char_one(8'h13), .stop_char_two(8'h93),
    .resume_char_one(8'h11), .resume_char_two(8'h91), .char_enable(cen),
    .input_pin_qualify(qual), .pin_match(pm), .half_bit_tick(tick), .tx_busy(busy),
    .tx_serial(txs), .rx_char_valid(rxv), .rx_char(rch), .rx_ninth_bit(ninth),
    .rx_parity_bad(pbad), .rx_fifo_level(lvl), .rx_pin(rxp), .cts_pin(ctsp),
    .tx_pin_o(tpo), .tx_pin_oe(toe), .rts_pin_o(rts), .rx_serial(rxs), .cts_internal(ctsi),
    .rx_accept(acc), .check_bit_enable(cbe), .check_sense_even(cse),
    .constant_check_bit(ccb), .constant_level(clv), .data_bits(dbits),
    .extended_stop_select(ext), .frame_half_bits(fhb), .fifo_clear(fclr),
    .parity_flag(pflag), .match_char_event(mev), .flow_char_event(fev),
    .rx_empty_event(eev), .rx_threshold_event(tev), .rx_idle_timeout(tout));
  ulc_xcvr_model far (.tx_pin_o(tpo), .tx_pin_oe(toe), .cts_drive(ctsd),
    .line_level(line), .rx_pin(rxp), .cts_pin(ctsp));
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("FAIL %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk) #1 reg_wr = 1'b1;
    addr = a;
    wdata = d;
    @(posedge clk) #1 reg_wr = 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge clk) #1 reg_rd = 1'b1;
    addr = a;
    @(posedge clk) #1 reg_rd = 1'b0;
    chk("reg_rdata", rdata, e);
  endtask
  task automatic tk(input int n);
    repeat (n) begin
      @(posedge clk) #1 tick = 1'b1;
      @(posedge clk) #1 tick = 1'b0;
    end
  endtask
  task automatic pulse_rx();
    @(posedge clk) #1 rxv = 1'b1;
    @(posedge clk) #1 rxv = 1'b0;
  endtask
  // frame length in half bits: start, data, parity, stop
  function automatic logic [4:0] fl(input logic [7:0] l);
    logic [4:0] s;
    s = l[2] ? ((l[1:0] == 2'h0) ? 5'h03 : 5'h04) : 5'h02;
    return 5'(2 * (6 + l[1:0] + l[3])) + s;
  endfunction
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_reset();
    rd(ulc_pkg::ADDR_MODE, ulc_pkg::MODE_RST);
    rd(ulc_pkg::ADDR_LINE, ulc_pkg::LINE_RST);
    rd(ulc_pkg::ADDR_TOUT, ulc_pkg::TOUT_RST);
    rd(8'h0D, 8'h00);
    chk("rx_accept", acc, 1);
    chk("tx_pin_oe", toe, 1);
  endtask
  task automatic t_framing();
    logic [7:0] tbl [8] = '{8'h00, 8'h04, 8'h07, 8'h0B, 8'h1A, 8'h39, 8'h2E, 8'h13};
    foreach (tbl[i]) begin
      wr(ulc_pkg::ADDR_LINE, tbl[i]);
      rd(ulc_pkg::ADDR_LINE, tbl[i]);
      chk("check_bit_enable", cbe, tbl[i][3]);
      chk("check_sense_even", cse, tbl[i][4]);
      chk("extended_stop", ext, tbl[i][2]);
      chk("frame_half_bits", fhb, fl(tbl[i]));
      chk("data_bits", dbits, 5 + tbl[i][1:0]);
      if (tbl[i][5]) begin
        chk("constant_check_bit", ccb, 1);
        chk("constant_level", clv, !tbl[i][4]);
      end
    end
  endtask
  task automatic t_break();
    wr(ulc_pkg::ADDR_LINE, 8'h45);
    cyc(3);
    chk("tx_pin_o", tpo, 0);
    chk("line", line, 0);
    cyc(20);
    chk("tx_pin_o", tpo, 0);
    wr(ulc_pkg::ADDR_LINE, 8'h05);
    cyc(3);
    chk("tx_pin_o", tpo, 1);
  endtask
  task automatic t_loop_rts();
    wr(ulc_pkg::ADDR_MODE, 8'h20);
    wr(ulc_pkg::ADDR_LINE, 8'h85);
    ctsd = 1'b0;
    txs = 1'b0;
    cyc(4);
    chk("tx_pin_oe", toe, 0);
    chk("rts_pin_o", rts, 1);
    chk("cts_internal", ctsi, 1);
    chk("rx_serial", rxs, 0);
    txs = 1'b1;
    cyc(4);
    chk("rx_serial", rxs, 1);
    clko = 1'b1;
    wr(ulc_pkg::ADDR_LINE, 8'h05);
    cyc(3);
    chk("rts_frozen", rts, 1);
    clko = 1'b0;
    cyc(3);
    chk("rts_pin_o", rts, 0);
    wr(ulc_pkg::ADDR_MODE, 8'h00);
    cyc(4);
    chk("tx_pin_oe", toe, 1);
  endtask
  task automatic t_echo();
    hold = 4'h2;
    wr(ulc_pkg::ADDR_MODE, 8'h80);
    busy = 1'b1;
    cyc(2);
    chk("rx_accept", acc, 0);
    busy = 1'b0;
    tk(2);
    chk("rx_accept_hold", acc, 0);
    tk(8);
    cyc(2);
    chk("rx_accept", acc, 1);
    wr(ulc_pkg::ADDR_MODE, 8'h00);
  endtask
  task automatic t_timeout();
    wr(ulc_pkg::ADDR_TOUT, 8'h01);
    pulse_rx();
    tk(10);
    chk("rx_idle_timeout", tout, 0);
    tk(12);
    chk("rx_idle_timeout", tout, 1);
    wr(ulc_pkg::ADDR_TOUT, 8'h00);
    pulse_rx();
    tk(40);
    chk("rx_idle_timeout_off", tout, 0);
  endtask
  task automatic t_mdrop();
    wr(ulc_pkg::ADDR_LINE, 8'h0D);
    wr(ulc_pkg::ADDR_MODE, 8'h40);
    ninth = 1'b1;
    pulse_rx();
    cyc(2);
    chk("parity_flag", pflag, 1);
    chk("check_bit_enable", cbe, 0);
    ninth = 1'b0;
    pulse_rx();
    cyc(2);
    chk("parity_flag", pflag, 0);
    wr(ulc_pkg::ADDR_MODE, 8'h00);
  endtask
  task automatic t_events();
    pbad = 1'b1;
    pulse_rx();
    chk("parity_flag", pflag, 1);
    pbad = 1'b0;
    wr(ulc_pkg::ADDR_MODE, 8'h10);
    cen = 4'hF;
    rch = 8'h91;
    pulse_rx();
    chk("match_char_event", mev, 1);
    qual = 1'b1;
    pulse_rx();
    chk("match_char_qual", mev, 0);
    pm = 1'b1;
    pulse_rx();
    chk("match_char_pin", mev, 1);
    qual = 1'b0;
    asfe = 1'b1;
    rch = 8'h13;
    pulse_rx();
    chk("match_char_flow", mev, 0);
    chk("flow_char_event", fev, 2'h2);
    rch = 8'h93;
    pulse_rx();
    chk("match_char_two", mev, 1);
    asfe = 1'b0;
    hold = 4'h0;
    wr(ulc_pkg::ADDR_MODE, 8'h90);
    busy = 1'b1;
    pulse_rx();
    chk("match_char_echo", mev, 0);
    busy = 1'b0;
    wr(ulc_pkg::ADDR_MODE, 8'h00);
    thr = 4'h1;
    lvl = 8'h08;
    cyc(1);
    chk("rx_threshold_event", tev, 0);
    lvl = 8'h09;
    cyc(1);
    chk("rx_threshold_event", tev, 1);
    lvl = 8'h00;
    cyc(1);
    chk("rx_empty_event", eev, 1);
    wr(ulc_pkg::ADDR_MODE, 8'h0C);
    lvl = 8'h09;
    cyc(1);
    chk("rx_empty_event_inv", eev, 1);
    chk("rx_threshold_event", tev, 0);
    lvl = 8'h07;
    cyc(1);
    chk("rx_threshold_event_inv", tev, 1);
    lvl = 8'h00;
    wr(ulc_pkg::ADDR_MODE, 8'h00);
  endtask
  task automatic t_flush_srst();
    wr(ulc_pkg::ADDR_MODE, 8'h02);
    chk("fifo_clear", fclr, 1);
    rd(ulc_pkg::ADDR_MODE, 8'h02);
    wr(ulc_pkg::ADDR_MODE, 8'h00);
    chk("fifo_clear", fclr, 0);
    wr(ulc_pkg::ADDR_LINE, 8'h1F);
    wr(ulc_pkg::ADDR_TOUT, 8'h33);
    wr(ulc_pkg::ADDR_MODE, 8'h01);
    cyc(2);
    rd(ulc_pkg::ADDR_LINE, ulc_pkg::LINE_RST);
    rd(ulc_pkg::ADDR_TOUT, 8'h00);
    chk("fifo_clear", fclr, 1);
    wr(ulc_pkg::ADDR_MODE, 8'h00);
    rd(ulc_pkg::ADDR_MODE, 8'h00);
    chk("frame_half_bits", fhb, 5'h12);
  endtask
  // ----------------------------------------
  // run control
  // ----------------------------------------
  task automatic summarize();
    if (n_errors == 0 && num_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  initial begin
    // watchdog at 10000 cycles, well above the full sequence
    #200000;
    n_errors++;
    summarize();
  end
  initial begin
    {nrst, reg_wr, reg_rd, tick, busy, rxv, ninth, clko, ctsd} = 9'h000;
    txs = 1'b1;
    addr = 8'h00;
    wdata = 8'h00;
    hold = 4'h0;
    {asfe, qual, pm, pbad} = 4'h0;
    thr = 4'h0;
    cen = 4'h0;
    rch = 8'h5A;
    lvl = 8'h00;
    repeat (12) @(posedge clk);
    #1 nrst = 1'b1;
    cyc(1);
    t_reset();
    t_framing();
    t_break();
    t_loop_rts();
    t_echo();
    t_timeout();
    t_mdrop();
    t_events();
    t_flush_srst();
    summarize();
  end
endmodule // uart_line_and_mode_control_tb
